// ### verilog/mbio_top.sv
// Multiplexed bus interface with two bidirectional ports
// Functional notes
// [RULE_01] Bus cycle is oscillator divided by five
// [RULE_02] Outside latches low address on strobe fall
// [RULE_03] Address strobe once per cycle unless halted
// [RULE_04] Data strobe every cycle, internal included; here halted cycles get no data strobe
// [RULE_05] Read/write high on reads, rests high
// [RULE_06] Shared bus: address then data phase
// [RULE_07] Upper address lines held whole cycle
// [RULE_08] Peripherals tolerate redundant opcode reads
// [RULE_09] Address strobe high; strobe spacing minimum
// [RULE_10] Interrupt taken only at instruction end
// [RULE_11] Catch both level and pulse requests
// [RULE_12] Pulse sources space by routine plus twenty
// [RULE_13] Fetch flag with strobe, low in interrupts
// [RULE_14] Direction bit one drives, zero inputs
// [RULE_15] Output value latched and read back
// [RULE_16] Input reads return live pin level
// [RULE_17] Reset clears direction, keeps latches
// [RULE_18] Direction register readable and writable
// [RULE_19] Second port identical to the first
// [RULE_20] Writes to input pins update latch
// [RULE_21] On-chip accesses repeated on external bus
// [RULE_22] Address strobe precedes data strobe
module mbio_top #(
	parameter int HI_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic osc_in,
	input wire logic halt,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_fetch,
	input wire logic req_in_irq,
	input wire logic [HI_W+7:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic [7:0] rsp_rdata,
	output logic rsp_valid,
	input wire logic irq_n,
	input wire logic mask_i,
	input wire logic insn_end,
	input wire logic irq_taken,
	output logic irq_start,
	output logic addr_strobe,
	output logic data_strobe,
	output logic rd_wr,
	output logic opcode_fetch_flag,
	output logic [HI_W-1:0] upper_addr_lines,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic [7:0] bus_oe_n,
	input wire logic [7:0] port_first_pins_in,
	output logic [7:0] port_first_pins_out,
	output logic [7:0] port_first_pins_oe_n,
	input wire logic [7:0] port_second_pins_in,
	output logic [7:0] port_second_pins_out,
	output logic [7:0] port_second_pins_oe_n
);
	typedef mbio_pkg::mbio_state_t mbio_st_t;

	// Match for on-chip port locations
	function automatic logic hit(input logic [HI_W+7:0] a,
		input logic [15:0] loc);
		hit = (a == (HI_W+8)'(loc));
	endfunction : hit

	// ==========================================================
	// Oscillator edge detect and divide-by-five
	logic osc_q, osc_d;
	logic [2:0] ph_q, ph_d;
	logic osc_rise;
	mbio_st_t st_q, st_d;
	logic as_q, as_d, ds_q, ds_d, rw_q, rw_d, lf_q, lf_d;
	logic [7:0] bo_q, bo_d, oe_q, oe_d, rd_q, rd_d;
	logic [HI_W-1:0] hi_q, hi_d;
	logic [HI_W+7:0] a_q, a_d;
	logic wr_q, wr_d, rv_q, rv_d;
	logic [7:0] wd_q, wd_d;
	logic int_q, int_d;
	logic [7:0] pa_rd, pb_rd, pa_dir, pb_dir;
	logic pa_wr, pb_wr, pa_dw, pb_dw, commit;

	assign osc_rise = osc_in & ~osc_q;
	// No request is taken while halted: the cycle would never run
	assign req_ready = osc_rise && (ph_q == mbio_pkg::PH_LAST) && !halt;
	// Write lands in the on-chip location mid data strobe, on the PH_DS1 oscillator edge
	assign commit = osc_rise && (ph_q == mbio_pkg::PH_DS1) && wr_q;
	assign pa_wr = commit & hit(a_q, mbio_pkg::ADDR_PORT_A);
	assign pb_wr = commit & hit(a_q, mbio_pkg::ADDR_PORT_B);
	assign pa_dw = commit & hit(a_q, mbio_pkg::ADDR_DIR_A);
	assign pb_dw = commit & hit(a_q, mbio_pkg::ADDR_DIR_B);

	always_comb begin
		osc_d = osc_in;
		ph_d = ph_q;
		if (osc_rise) begin
			// Five oscillator edges per bus cycle
			ph_d = (ph_q == mbio_pkg::PH_LAST) ? mbio_pkg::PH_AS
				: 3'(ph_q + 3'h1); // [RULE_01]
		end
	end

	// ==========================================================
	// Bus cycle sequencer
	always_comb begin
		st_d = st_q;
		as_d = as_q;
		ds_d = ds_q;
		rw_d = rw_q;
		lf_d = lf_q;
		bo_d = bo_q;
		oe_d = oe_q;
		hi_d = hi_q;
		a_d = a_q;
		wr_d = wr_q;
		wd_d = wd_q;
		int_d = int_q;
		rd_d = rd_q;
		rv_d = 1'b0;
		if (osc_rise) begin
			case (ph_q)
				mbio_pkg::PH_LAST: begin
					ds_d = 1'b0;
					oe_d = 8'hFF;
					if (halt) begin
						st_d = mbio_pkg::MBIO_IDLE; // [RULE_03]
						rw_d = 1'b1; // [RULE_05]
						lf_d = 1'b0;
					end else begin
						st_d = mbio_pkg::MBIO_ADDR;
						as_d = 1'b1; // [RULE_03]
						a_d = req_valid ? req_addr : a_q;
						wr_d = req_valid & req_write;
						wd_d = req_wdata;
						int_d = req_valid & req_in_irq;
						rw_d = ~(req_valid & req_write); // [RULE_05]
						hi_d = req_addr[HI_W+7:8]; // [RULE_07]
						bo_d = req_addr[7:0]; // [RULE_06]
						oe_d = 8'h00;
						// Fetch flag held low during interrupt stacking
						lf_d = req_valid & req_fetch & ~req_in_irq; // [RULE_13]
					end
				end
				mbio_pkg::PH_AS: begin
					// Halted cycles stay idle, so no data strobe follows
					if (st_q == mbio_pkg::MBIO_ADDR) begin
						st_d = mbio_pkg::MBIO_GAP; // [RULE_04]
					end
				end
				mbio_pkg::PH_GAP: begin
					as_d = 1'b0; // [RULE_09]
					if (st_q == mbio_pkg::MBIO_GAP) begin
						st_d = mbio_pkg::MBIO_DATA;
						// Internal reads also go out; bus is released anyway
						bo_d = wd_q; // [RULE_21]
						oe_d = wr_q ? 8'h00 : 8'hFF; // [RULE_06]
					end
				end
				mbio_pkg::PH_DS0: begin
					ds_d = (st_q == mbio_pkg::MBIO_DATA); // [RULE_04] [RULE_22]
				end
				mbio_pkg::PH_DS1: begin
					if (st_q == mbio_pkg::MBIO_DATA) begin
						rv_d = 1'b1;
						// Internal locations override external read data
						if (hit(a_q, mbio_pkg::ADDR_PORT_A)) begin
							rd_d = pa_rd; // [RULE_21]
						end else if (hit(a_q, mbio_pkg::ADDR_PORT_B)) begin
							rd_d = pb_rd;
						end else if (hit(a_q, mbio_pkg::ADDR_DIR_A)) begin
							rd_d = pa_dir;
						end else if (hit(a_q, mbio_pkg::ADDR_DIR_B)) begin
							rd_d = pb_dir;
						end else begin
							rd_d = bus_in;
						end
					end
				end
				default: begin
					st_d = mbio_pkg::MBIO_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_q <= 1'b0;
			ph_q <= mbio_pkg::PH_AS;
			st_q <= mbio_pkg::MBIO_IDLE;
			as_q <= 1'b0;
			ds_q <= 1'b0;
			rw_q <= 1'b1;
			lf_q <= 1'b0;
			bo_q <= 8'h00;
			oe_q <= 8'hFF;
			hi_q <= '0;
			a_q <= '0;
			wr_q <= 1'b0;
			wd_q <= 8'h00;
			int_q <= 1'b0;
			rd_q <= 8'h00;
			rv_q <= 1'b0;
		end else begin
			osc_q <= osc_d;
			ph_q <= ph_d;
			st_q <= st_d;
			as_q <= as_d;
			ds_q <= ds_d;
			rw_q <= rw_d;
			lf_q <= lf_d;
			bo_q <= bo_d;
			oe_q <= oe_d;
			hi_q <= hi_d;
			a_q <= a_d;
			wr_q <= wr_d;
			wd_q <= wd_d;
			int_q <= int_d;
			rd_q <= rd_d;
			rv_q <= rv_d;
		end
	end

	always_comb begin
		addr_strobe = as_q;
		data_strobe = ds_q;
		rd_wr = rw_q;
		opcode_fetch_flag = lf_q;
		upper_addr_lines = hi_q;
		bus_out = bo_q;
		bus_oe_n = oe_q;
		rsp_rdata = rd_q;
		rsp_valid = rv_q;
	end

	// ==========================================================
	// Ports A and B
	mbio_port #(.WIDTH(8)) u_port_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_data(pa_wr),
		.wr_dir(pa_dw),
		.wdata(wd_q),
		.pin_in(port_first_pins_in),
		.pin_out(port_first_pins_out),
		.pin_oe_n(port_first_pins_oe_n),
		.rd_data(pa_rd),
		.rd_dir(pa_dir)
	);

	mbio_port #(.WIDTH(8)) u_port_b ( // [RULE_19]
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_data(pb_wr),
		.wr_dir(pb_dw),
		.wdata(wd_q),
		.pin_in(port_second_pins_in),
		.pin_out(port_second_pins_out),
		.pin_oe_n(port_second_pins_oe_n),
		.rd_data(pb_rd),
		.rd_dir(pb_dir)
	);

	mbio_irq u_irq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.irq_n(irq_n),
		.mask_i(mask_i),
		.insn_end(insn_end),
		.irq_taken(irq_taken),
		.irq_start(irq_start)
	);

	// ==========================================================
	// Checks
	a_as_no_ds: assert property (@(posedge sys_clk) // [RULE_22]
		disable iff (!rst_n) !(addr_strobe && data_strobe))
		else $error("strobes overlap");
	a_ds_phase: assert property (@(posedge sys_clk) // [RULE_04]
		disable iff (!rst_n) $rose(data_strobe) |-> (ph_q == mbio_pkg::PH_DS1))
		else $error("data strobe off phase");
	a_as_high: assert property (@(posedge sys_clk) // [RULE_09]
		disable iff (!rst_n) $rose(addr_strobe) |=> addr_strobe [*8])
		else $error("address strobe too short");
	a_rw_rest: assert property (@(posedge sys_clk) // [RULE_05]
		disable iff (!rst_n) (st_q == mbio_pkg::MBIO_IDLE) |-> rd_wr)
		else $error("read/write not resting high");
	a_bus_read: assert property (@(posedge sys_clk) // [RULE_06]
		disable iff (!rst_n) (data_strobe && rd_wr) |-> (bus_oe_n == 8'hFF))
		else $error("bus driven during read");
	a_hi_hold: assert property (@(posedge sys_clk) // [RULE_07]
		disable iff (!rst_n)
		(ph_q != mbio_pkg::PH_AS && $changed(ph_q)) |-> $stable(upper_addr_lines))
		else $error("upper address moved mid cycle");
	a_lf_irq: assert property (@(posedge sys_clk) // [RULE_13]
		disable iff (!rst_n) int_q |-> !opcode_fetch_flag)
		else $error("fetch flag high in interrupt");
	a_div5: assert property (@(posedge sys_clk) // [RULE_01]
		disable iff (!rst_n) ph_q <= mbio_pkg::PH_LAST)
		else $error("phase count out of range");
endmodule : mbio_top

// ### shared/mbio_pkg.sv
// Constants and types of the multiplexed bus and I/O port block
package mbio_pkg;
	// ==========================================================
	// Bus cycle timing
	localparam int OSC_DIV = 5;
	localparam int SYS_CLK_MHZ = 250;
	localparam int AS_HIGH_MIN_NS = 175;
	localparam int AS_TO_DS_MIN_NS = 160;
	localparam int AS_HIGH_CYC =
		(AS_HIGH_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int AS_TO_DS_CYC =
		(AS_TO_DS_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	// Phase of osc_in count 0..4 for each strobe
	localparam logic [2:0] PH_AS = 3'h0;
	localparam logic [2:0] PH_GAP = 3'h1;
	localparam logic [2:0] PH_DS0 = 3'h2;
	localparam logic [2:0] PH_DS1 = 3'h3;
	localparam logic [2:0] PH_LAST = 3'h4;
	// ==========================================================
	// Internal map: on-chip port locations
	localparam logic [15:0] ADDR_PORT_A = 16'h0000;
	localparam logic [15:0] ADDR_PORT_B = 16'h0001;
	localparam logic [15:0] ADDR_DIR_A = 16'h0004;
	localparam logic [15:0] ADDR_DIR_B = 16'h0005;
	localparam logic [7:0] DIR_RESET = 8'h00;
	// ==========================================================
	// Bus cycle states, one-hot
	typedef enum logic [3:0] {
		MBIO_IDLE = 4'h1,
		MBIO_ADDR = 4'h2,
		MBIO_GAP = 4'h4,
		MBIO_DATA = 4'h8
	} mbio_state_t;
endpackage : mbio_pkg

// ### verilog/mbio_port.sv
// One eight-pin bidirectional port with direction register and latch
module mbio_port #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wr_data,
	input wire logic wr_dir,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output logic [WIDTH-1:0] rd_data,
	output logic [WIDTH-1:0] rd_dir
);
	logic [WIDTH-1:0] dir_q, dir_d;
	logic [WIDTH-1:0] latch_q, latch_d;

	// ==========================================================
	// Next state
	always_comb begin
		dir_d = wr_dir ? wdata : dir_q; // [RULE_18]
		latch_d = wr_data ? wdata : latch_q; // [RULE_20]
	end

	// Direction clears on reset; latch keeps contents
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= WIDTH'(mbio_pkg::DIR_RESET); // [RULE_17]
		end else begin
			dir_q <= dir_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		latch_q <= latch_d; // [RULE_15]
	end

	// ==========================================================
	// Pin drive and readback mix
	always_comb begin
		pin_out = latch_q;
		pin_oe_n = ~dir_q; // [RULE_14]
		rd_dir = dir_q;
		// Live pin for inputs, latch for outputs
		rd_data = (dir_q & latch_q) | (~dir_q & pin_in); // [RULE_16]
	end

	a_dir_drive: assert property (@(posedge sys_clk) // [RULE_14]
		disable iff (!rst_n) pin_oe_n == ~dir_q)
		else $error("pin enable not tied to direction");
	a_write_lat: assert property (@(posedge sys_clk) // [RULE_15]
		disable iff (!rst_n) wr_data |=> (latch_q == $past(wdata)))
		else $error("latch missed a write");
	a_in_live: assert property (@(posedge sys_clk) // [RULE_16]
		disable iff (!rst_n) (dir_q == '0) |-> (rd_data == pin_in))
		else $error("input read not live");
	a_dir_wr: assert property (@(posedge sys_clk) // [RULE_18]
		disable iff (!rst_n) wr_dir |=> (rd_dir == $past(wdata)))
		else $error("direction readback wrong");
endmodule : mbio_port

// ### verilog/mbio_irq.sv
// Interrupt request catcher for level and short pulse requests
module mbio_irq (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic irq_n,
	input wire logic mask_i,
	input wire logic insn_end,
	input wire logic irq_taken,
	output logic irq_start
);
	logic irq_prev_q, irq_prev_d;
	logic edge_q, edge_d;

	// ==========================================================
	// Falling edge latch plus live level
	always_comb begin
		irq_prev_d = irq_n;
		// Set wins over the clear by service start
		edge_d = (irq_prev_q & ~irq_n) | (edge_q & ~irq_taken); // [RULE_11]
		irq_start = insn_end & ~mask_i & (edge_q | ~irq_n); // [RULE_10]
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_prev_q <= 1'b1;
			edge_q <= 1'b0;
		end else begin
			irq_prev_q <= irq_prev_d;
			edge_q <= edge_d;
		end
	end

	a_irq_wait: assert property (@(posedge sys_clk) // [RULE_10]
		disable iff (!rst_n) irq_start |-> (insn_end && !mask_i))
		else $error("interrupt started mid instruction");
	// The set wins even when a clear arrives in the same cycle
	a_pulse_kept: assert property (@(posedge sys_clk) // [RULE_11]
		disable iff (!rst_n) (irq_prev_q && !irq_n) |=> edge_q)
		else $error("short request pulse lost");
endmodule : mbio_irq

// ### bench/mbio_mem_model.sv
// Behavioural external memory with a low-address latch
module mbio_mem_model (
	input wire logic sys_clk,
	input wire logic addr_strobe,
	input wire logic data_strobe,
	input wire logic rd_wr,
	input wire logic [7:0] upper_addr_lines,
	input wire logic [7:0] bus_lvl,
	output logic [7:0] rd_val,
	output logic [15:0] last_wa,
	output logic [7:0] last_wd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	logic [7:0] lat = 8'h00;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'hC3;
		rd_val = 8'h00;
		last_wa = 16'h0000;
		last_wd = 8'h00;
	end
	// ==========================================================
	// Latch, read drive and write capture
	always @(posedge sys_clk) begin
		// Transparent while high, so it holds what stood at the fall
		if (addr_strobe)
			lat <= bus_lvl;
		// Reads only look; a released bus toggles every cycle
		if (data_strobe && rd_wr)
			rd_val <= mem[lat];
		else
			rd_val <= ~rd_val;
		if (data_strobe && !rd_wr) begin
			mem[lat] <= bus_lvl;
			last_wa <= {upper_addr_lines, lat};
			last_wd <= bus_lvl;
		end
	end
endmodule : mbio_mem_model

// ### bench/tb.sv
// Self-checking bench for the multiplexed bus and port block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0, rst_n = 1'b0, osc_in = 1'b0, halt = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
	logic req_in_irq = 1'b0, irq_n = 1'b1, mask_i = 1'b1;
	logic insn_end = 1'b0, irq_taken = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0] req_wdata = 8'h00, pa_ext = 8'h3C, pb_ext = 8'h3C;
	logic req_ready, rsp_valid, irq_start, addr_strobe, data_strobe;
	logic rd_wr, opcode_fetch_flag;
	logic [7:0] rsp_rdata, upper_addr_lines, bus_in, bus_out, bus_oe_n;
	logic [7:0] pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n, rd_val;
	logic [7:0] last_wd, rd;
	logic [15:0] last_wa;
	logic fetch_seen, rw_at_ds;
	int n_mismatch = 0;
	int checks = 0;
	assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & pa_ext);
	assign pb_in = (~pb_oe_n & pb_out) | (pb_oe_n & pb_ext);
	assign bus_in = (~bus_oe_n & bus_out) | (bus_oe_n & rd_val);
	initial forever #2 sys_clk = ~sys_clk;
	// Oscillator of 200 ns: fastest documented rate
	initial forever begin
		repeat (25) @(posedge sys_clk);
		osc_in <= ~osc_in;
	end
	mbio_top mbio_top_i (.sys_clk, .rst_n, .osc_in, .halt, .req_valid,
		.req_write, .req_fetch, .req_in_irq, .req_addr, .req_wdata,
		.req_ready, .rsp_rdata, .rsp_valid, .irq_n, .mask_i, .insn_end,
		.irq_taken, .irq_start, .addr_strobe, .data_strobe, .rd_wr,
		.opcode_fetch_flag, .upper_addr_lines, .bus_in, .bus_out,
		.bus_oe_n, .port_first_pins_in(pa_in),
		.port_first_pins_out(pa_out), .port_first_pins_oe_n(pa_oe_n),
		.port_second_pins_in(pb_in), .port_second_pins_out(pb_out),
		.port_second_pins_oe_n(pb_oe_n));
	mbio_mem_model mbio_mem_model_i (.sys_clk, .addr_strobe,
		.data_strobe, .rd_wr, .upper_addr_lines, .bus_lvl(bus_in),
		.rd_val, .last_wa, .last_wd);
	// ==========================================================
	// Shared tasks
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic hang(string what);
		chk(what, 16'h0001, 16'h0000);
		results();
	endtask : hang
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// One request, held until ready, then followed to the strobe fall
	task automatic bus(logic w, logic f, logic [15:0] a, logic [7:0] d);
		int i;
		logic up;
		up = 1'b0;
		fetch_seen = 1'b0;
		req_valid <= 1'b1;
		req_write <= w;
		req_fetch <= f;
		req_addr <= a;
		req_wdata <= d;
		for (i = 0; i < 600; i++) begin
			@(posedge sys_clk);
			if (req_ready === 1'b1)
				break;
		end
		if (i == 600)
			hang("ready");
		req_valid <= 1'b0;
		for (i = 0; i < 600; i++) begin
			@(posedge sys_clk);
			if (rsp_valid === 1'b1)
				rd = rsp_rdata;
			if (data_strobe === 1'b1) begin
				up = 1'b1;
				rw_at_ds = rd_wr;
				if (opcode_fetch_flag === 1'b1)
					fetch_seen = 1'b1;
			end else if (up)
				break;
		end
		if (i == 600)
			hang("data strobe");
	endtask : bus
	// ==========================================================
	// Scenarios
	task automatic t_timing();
		int i, t, h, g;
		logic prev;
		prev = 1'b1;
		h = 0;
		g = 0;
		for (i = 0; i < 600; i++) begin
			@(posedge sys_clk);
			if (addr_strobe === 1'b1 && !prev)
				break;
			prev = addr_strobe;
		end
		if (i == 600)
			hang("strobe rise");
		for (t = 1; t < 600; t++) begin
			@(posedge sys_clk);
			if (addr_strobe === 1'b1 && h != 0)
				break;
			if (addr_strobe === 1'b0 && h == 0)
				h = t;
			if (data_strobe === 1'b1 && g == 0)
				g = t;
		end
		chk("cycle clocks", 16'(mbio_pkg::OSC_DIV * 50), 16'(t));
		chk("as high", 16'h0001, 16'(h >= mbio_pkg::AS_HIGH_CYC));
		chk("as to ds", 16'h0001, 16'(g - h >= mbio_pkg::AS_TO_DS_CYC));
		$display("test timing done");
	endtask : t_timing
	task automatic t_ext();
		bus(1'b1, 1'b0, 16'h2A81, 8'h5C);
		chk("write addr", 16'h2A81, last_wa);
		chk("write data", 16'h005C, 16'(last_wd));
		chk("rw on write", 16'h0000, 16'(rw_at_ds));
		tick(2);
		chk("rw rest", 16'h0001, 16'(rd_wr));
		bus(1'b0, 1'b1, 16'h3A81, 8'h00);
		chk("read data", 16'h005C, 16'(rd));
		chk("rw on read", 16'h0001, 16'(rw_at_ds));
		chk("fetch flag", 16'h0001, 16'(fetch_seen));
		req_in_irq <= 1'b1;
		bus(1'b0, 1'b1, 16'h3A81, 8'h00);
		req_in_irq <= 1'b0;
		chk("flag in irq", 16'h0000, 16'(fetch_seen));
		$display("test external done");
	endtask : t_ext
	task automatic t_port(logic b);
		logic [15:0] pa, da;
		pa = b ? mbio_pkg::ADDR_PORT_B : mbio_pkg::ADDR_PORT_A;
		da = b ? mbio_pkg::ADDR_DIR_B : mbio_pkg::ADDR_DIR_A;
		bus(1'b1, 1'b0, da, 8'hF0);
		bus(1'b1, 1'b0, pa, 8'h5A);
		chk("echo addr", pa, last_wa);
		chk("echo data", 16'h005A, 16'(last_wd));
		bus(1'b0, 1'b0, pa, 8'h00);
		chk("port read", 16'h005C, 16'(rd));
		bus(1'b0, 1'b0, da, 8'h00);
		chk("dir read", 16'h00F0, 16'(rd));
		chk("oe_n", 16'h000F, 16'(b ? pb_oe_n : pa_oe_n));
		chk("pin out", 16'h005A, 16'(b ? pb_out : pa_out));
		if (b)
			pb_ext <= 8'hC3;
		else
			pa_ext <= 8'hC3;
		bus(1'b0, 1'b0, pa, 8'h00);
		chk("live read", 16'h0053, 16'(rd));
		bus(1'b1, 1'b0, da, 8'h00);
		bus(1'b1, 1'b0, pa, 8'hA5);
		chk("input oe_n", 16'h00FF, 16'(b ? pb_oe_n : pa_oe_n));
		chk("input latch", 16'h00A5, 16'(b ? pb_out : pa_out));
		bus(1'b1, 1'b0, da, 8'h0F);
		$display("test port done");
	endtask : t_port
	task automatic t_reset();
		rst_n <= 1'b0;
		tick(3);
		chk("reset oe a", 16'h00FF, 16'(pa_oe_n));
		chk("reset oe b", 16'h00FF, 16'(pb_oe_n));
		rst_n <= 1'b1;
		tick(2);
		chk("kept a", 16'h00A5, 16'(pa_out));
		chk("kept b", 16'h00A5, 16'(pb_out));
		bus(1'b0, 1'b0, mbio_pkg::ADDR_DIR_B, 8'h00);
		chk("dir after reset", 16'h0000, 16'(rd));
		$display("test reset done");
	endtask : t_reset
	task automatic t_halt();
		int n, m;
		logic prev, pd;
		n = 0;
		m = 0;
		prev = 1'b1;
		pd = 1'b1;
		halt <= 1'b1;
		tick(300);
		repeat (300) begin
			@(posedge sys_clk);
			if (addr_strobe === 1'b1 && !prev)
				n++;
			if (data_strobe === 1'b1 && !pd)
				m++;
			prev = addr_strobe;
			pd = data_strobe;
		end
		chk("halted strobes", 16'h0000, 16'(n));
		chk("halted ds", 16'h0000, 16'(m));
		chk("halted rw", 16'h0001, 16'(rd_wr));
		halt <= 1'b0;
		tick(2);
		$display("test halt done");
	endtask : t_halt
	task automatic t_irq();
		// One pulse only, so the spacing a pulsing source owes is kept
		irq_n <= 1'b0;
		tick(3);
		irq_n <= 1'b1;
		insn_end <= 1'b1;
		tick(2);
		chk("masked", 16'h0000, 16'(irq_start));
		mask_i <= 1'b0;
		tick(1);
		chk("pulse caught", 16'h0001, 16'(irq_start));
		insn_end <= 1'b0;
		tick(1);
		chk("mid insn", 16'h0000, 16'(irq_start));
		irq_taken <= 1'b1;
		tick(1);
		irq_taken <= 1'b0;
		insn_end <= 1'b1;
		tick(2);
		chk("cleared", 16'h0000, 16'(irq_start));
		irq_n <= 1'b0;
		tick(2);
		chk("level", 16'h0001, 16'(irq_start));
		irq_n <= 1'b1;
		insn_end <= 1'b0;
		$display("test irq done");
	endtask : t_irq
	initial begin
		tick(8);
		rst_n <= 1'b1;
		tick(2);
		t_timing();
		t_ext();
		t_port(1'b0);
		t_port(1'b1);
		t_reset();
		t_halt();
		t_irq();
		results();
	end
endmodule : tb
